// file: core/lrfc_msg_mem.sv
`default_nettype none
// Message buffer with one write port and a registered read port.
module lrfc_msg_mem #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 128,
	parameter int unsigned AW    = 7
) (
	input  wire logic             clk,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Storage has no reset; software only reads what a frame wrote.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : lrfc_msg_mem
`default_nettype wire

// file: core/lrfc_pkg.sv
`default_nettype none
package lrfc_pkg;
	// Register word indices; byte address is four times the index.
	localparam logic [7:0] CTRL_IDX = 8'h18;
	localparam logic [7:0] STAT_IDX = 8'h19;
	localparam logic [7:0] BUF_IDX  = 8'h80;

	// Control register field positions and reset value.
	localparam int unsigned CTRL_IRQ_BIT  = 0;
	localparam int unsigned CTRL_MASK_BIT = 1;
	localparam int unsigned CTRL_ON_BIT   = 2;
	localparam int unsigned CTRL_SRC_BIT  = 3;
	localparam logic [7:0]  CTRL_RESET    = 8'h02;
	localparam logic [7:0]  STAT_RESET    = 8'h00;

	// Check sequence: reflected x16 + x12 + x5 + 1, preset and residue.
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hf0b8;

	// Frame layout in octets after the opening flag.
	localparam logic [7:0]  HDR_OCTETS = 8'h03;
	localparam logic [7:0]  MIN_OCTETS = 8'h05;
	localparam int unsigned CR_BIT     = 1;

	// First payload octet values and the kind codes they map to.
	localparam logic [7:0] ID_PATH = 8'h38;
	localparam logic [7:0] ID_IDLE = 8'h34;
	localparam logic [7:0] ID_TEST = 8'h32;
	localparam logic [7:0] ID_ITU  = 8'h3f;
	localparam logic [1:0] KIND_PATH = 2'h0;
	localparam logic [1:0] KIND_IDLE = 2'h1;
	localparam logic [1:0] KIND_TEST = 2'h2;
	localparam logic [1:0] KIND_ITU  = 2'h3;

	// Overhead octets offered once per received E3 frame.
	typedef struct packed {
		logic       valid;
		logic [7:0] gc;
		logic [7:0] nr;
	} lrfc_oh_t;

	// Status register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic       unused;
		logic       abort_seen;
		logic [1:0] message_kind_code;
		logic       command_response_flag;
		logic       check_sequence_error;
		logic       message_complete_flag;
		logic       flag_present;
	} lrfc_status_t;

	typedef enum logic [2:0] {
		ST_HUNT = 3'h1,
		ST_OPEN = 3'h2,
		ST_DATA = 3'h4
	} lrfc_state_t;
endpackage : lrfc_pkg
`default_nettype wire

// file: core/lrfc_top.sv
`default_nettype none
// Contract
// - After a whole frame, check sequence covers header and message octets.
// - Status bit 2 is one on check mismatch, zero on match.
// - Message octets enter the buffer whether or not the check passed.
// - The command/response bit of header octet 2 is copied to status bit 3; the code takes it from header octet 1.
// - That bit zero means customer installation, one means network terminal.
// - First payload octet gives type and size in status bits 4 and 5.
// - Codes 00, 01, 10 mean 76 byte messages; 11 means 82 bytes.
// - After these steps raise the message interrupt, control 0x18 bit 0.
// - On frame completion set message_complete_flag, status 0x19 bit 1.
// - Frames are processed only while control bit 2 is one.
// - Control bit 3 picks the GC octet at zero, NR octet at one.
// - The check sequence uses x16 + x12 + x5 + 1.
// - Seven or more ones after a flag set the abort bit, status bit 6.
module lrfc_top #(
	parameter int unsigned ADDR_W    = 10,
	parameter int unsigned MSG_DEPTH = 128
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire lrfc_pkg::lrfc_oh_t   oh_in,
	input  wire logic [ADDR_W-1:0]    avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	output logic                      irq
);
	import lrfc_pkg::*;

	localparam int unsigned MAW = $clog2(MSG_DEPTH);

	// One octet step of the reflected check sequence, LSB first.
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
	                                         input logic [7:0]  d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction : crc_byte

	// Identifier octet to kind code; unknown values fall to path code.
	function automatic logic [1:0] kind_of(input logic [7:0] id);
		case (id)
			ID_IDLE: kind_of = KIND_IDLE;
			ID_TEST: kind_of = KIND_TEST;
			ID_ITU:  kind_of = KIND_ITU;
			default: kind_of = KIND_PATH;
		endcase
	endfunction : kind_of

	logic [7:0]     word_idx;
	logic           acc_done;
	logic           bus_pend;
	logic           ctrl_hit;
	logic [7:0]     ctrl;
	lrfc_status_t   status;
	logic           msg_received_irq_flag;
	logic           msg_received_irq_mask;
	logic           msg_receiver_on;
	logic           link_source_select;
	logic [7:0]     sh;
	logic [3:0]     bit_cnt;
	logic           bit_v;
	logic           b;
	logic [2:0]     ones;
	logic           is_flag;
	logic           is_abort;
	logic           is_stuff;
	logic           data_v;
	logic [2:0]     bit_pos;
	logic [7:0]     oct;
	logic [7:0]     oct_val;
	logic           oct_full;
	lrfc_state_t    state;
	logic [7:0]     oct_cnt;
	logic [15:0]    crc;
	logic           cr_cap;
	logic [1:0]     kind_cap;
	logic           frame_end;
	logic           done_q;
	logic           crc_ok_q;
	logic           mem_we;
	logic [MAW-1:0] mem_waddr;
	logic [7:0]     mem_rdata;
	logic [7:0]     ofs;

	assign word_idx = 8'(avs_address >> 2);
	assign acc_done = (avs_read | avs_write) & ~avs_waitrequest;
	assign ctrl_hit = word_idx == CTRL_IDX;
	assign msg_received_irq_flag = ctrl[CTRL_IRQ_BIT];
	assign msg_received_irq_mask = ctrl[CTRL_MASK_BIT];
	assign msg_receiver_on       = ctrl[CTRL_ON_BIT];
	assign link_source_select    = ctrl[CTRL_SRC_BIT];

	// Wait state sequencer: capture, then a cycle for the buffer read.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			bus_pend        <= 1'b0;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
			bus_pend        <= 1'b0;
		end else if ((avs_read | avs_write) && !bus_pend) begin
			bus_pend <= 1'b1;
		end else if (bus_pend) begin
			avs_waitrequest <= 1'b0;
		end
	end

	// Read data is loaded one edge before waitrequest is seen low.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0;
		end else if (bus_pend && avs_waitrequest) begin
			if (ctrl_hit) begin
				avs_readdata <= {24'h0, ctrl};
			end else if (word_idx == STAT_IDX) begin
				avs_readdata <= {24'h0, status};
			end else if (word_idx >= BUF_IDX) begin
				avs_readdata <= {24'h0, mem_rdata};
			end else begin
				avs_readdata <= 32'h0;
			end
		end
	end

	// Control bits; the flag is set by a finished frame and wins over
	// the read-clear or write-one-clear landing in the same cycle.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl <= CTRL_RESET;
		end else begin
			if (acc_done && avs_write && ctrl_hit) begin
				ctrl[3:1] <= avs_writedata[3:1];
			end
			if (done_q) begin
				ctrl[CTRL_IRQ_BIT] <= 1'b1;
			end else if (acc_done && ctrl_hit && (avs_read ||
			             avs_writedata[CTRL_IRQ_BIT])) begin
				ctrl[CTRL_IRQ_BIT] <= 1'b0;
			end
		end
	end

	// Registered interrupt level.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= msg_received_irq_flag & msg_received_irq_mask;
		end
	end

	// Serialiser: one overhead octet becomes eight bit cycles, LSB first.
	// An octet offered while eight bits are still shifting is dropped,
	// which is safe because octets arrive only once per E3 frame.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bit_cnt <= 4'h0;
			sh      <= 8'h0;
		end else if (bit_cnt != 4'h0) begin
			bit_cnt <= bit_cnt - 4'h1;
			sh      <= sh >> 1;
		end else if (oh_in.valid && msg_receiver_on) begin
			bit_cnt <= 4'h8;
			sh <= link_source_select ? oh_in.nr : oh_in.gc;
		end
	end

	assign bit_v    = bit_cnt != 4'h0;
	assign b        = sh[0];
	assign is_flag  = bit_v && !b && ones == 3'h6;
	assign is_abort = bit_v && b && ones == 3'h6;
	assign is_stuff = bit_v && !b && ones == 3'h5;
	assign data_v   = bit_v && !is_flag && !is_stuff && !is_abort;
	assign oct_val  = {b, oct[7:1]};
	assign oct_full = data_v && bit_pos == 3'h7;
	assign frame_end = is_flag && state == ST_DATA && bit_pos == 3'h7 &&
	                   oct_cnt >= MIN_OCTETS;

	// Run of ones, saturating at seven for abort detection.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ones <= 3'h0;
		end else if (bit_v) begin
			if (!b) begin
				ones <= 3'h0;
			end else if (ones != 3'h7) begin
				ones <= ones + 3'h1;
			end
		end
	end

	// Octet assembly; the flag's leading seven bits fill a partial octet
	// that the flag then discards, so only true octets ever complete.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bit_pos <= 3'h0;
			oct     <= 8'h0;
		end else if (is_flag) begin
			bit_pos <= 3'h0;
		end else if (data_v) begin
			bit_pos <= bit_pos + 3'h1;
			oct     <= oct_val;
		end
	end

	// Framing state: hunt for a flag, wait for the first octet, collect.
	always_ff @(posedge clk) begin
		if (!rst_b || !msg_receiver_on) begin
			state <= ST_HUNT;
		end else begin
			case (state)
				ST_HUNT: begin
					if (is_flag) begin
						state <= ST_OPEN;
					end
				end
				ST_OPEN: begin
					if (is_abort) begin
						state <= ST_HUNT;
					end else if (oct_full) begin
						state <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (is_abort) begin
						state <= ST_HUNT;
					end else if (is_flag) begin
						state <= ST_OPEN;
					end
				end
				default: state <= ST_HUNT;
			endcase
		end
	end

	// Octet count and running check over every octet up to the flag.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			oct_cnt <= 8'h0;
			crc     <= CRC_INIT;
		end else if (is_flag) begin
			oct_cnt <= 8'h0;
			crc     <= CRC_INIT;
		end else if (oct_full && state != ST_HUNT) begin
			if (oct_cnt != 8'hff) begin
				oct_cnt <= oct_cnt + 8'h1;
			end
			crc <= crc_byte(crc, oct_val);
		end
	end

	// Header and identifier capture while the frame streams in.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cr_cap   <= 1'b0;
			kind_cap <= KIND_PATH;
		end else if (oct_full && state == ST_OPEN) begin
			cr_cap <= oct_val[CR_BIT];
		end else if (oct_full && state == ST_DATA &&
		             oct_cnt == HDR_OCTETS) begin
			kind_cap <= kind_of(oct_val);
		end
	end

	// Frame completion is acted on one cycle after the closing flag.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			done_q   <= 1'b0;
			crc_ok_q <= 1'b0;
		end else begin
			done_q   <= frame_end;
			crc_ok_q <= crc == CRC_GOOD;
		end
	end

	// Status register.  Message_complete_flag and abort stay until the first
	// octet of the next frame so software has a whole frame to look.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			status <= STAT_RESET;
		end else begin
			if (is_flag) begin
				status.flag_present <= 1'b1;
			end else if (oct_full) begin
				status.flag_present <= 1'b0;
			end
			if (is_abort && state != ST_HUNT) begin
				status.abort_seen <= 1'b1;
			end else if (oct_full && state == ST_OPEN) begin
				status.abort_seen <= 1'b0;
			end
			if (done_q) begin
				status.check_sequence_error  <= !crc_ok_q;
				status.command_response_flag <= cr_cap;
				status.message_kind_code     <= kind_cap;
				status.message_complete_flag <= 1'b1;
			end else if (oct_full && state == ST_OPEN) begin
				status.message_complete_flag <= 1'b0;
			end
		end
	end

	// Payload and check octets go to the buffer; no check gates this.
	assign ofs       = oct_cnt - HDR_OCTETS;
	assign mem_waddr = ofs[MAW-1:0];
	assign mem_we    = oct_full && state == ST_DATA &&
	                   oct_cnt >= HDR_OCTETS && 32'(ofs) < MSG_DEPTH;

	lrfc_msg_mem #(
		.WIDTH (8),
		.DEPTH (MSG_DEPTH),
		.AW    (MAW)
	) u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (oct_val),
		.raddr (word_idx[MAW-1:0]),
		.rdata (mem_rdata)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence frame_close_s;
		frame_end ##1 done_q;
	endsequence

	irq_level_a: assert property (
		##1 irq == $past(msg_received_irq_flag && msg_received_irq_mask))
		else $error("interrupt output does not follow flag and enable");
	done_sets_a: assert property (
		frame_close_s |=> msg_received_irq_flag &&
		status.message_complete_flag)
		else $error("frame completion did not set flag and end bit");
	fcs_result_a: assert property (
		frame_end |=> ##1 status.check_sequence_error ==
		!$past(crc == CRC_GOOD, 2))
		else $error("check error bit disagrees with computed check");
	cr_copy_a: assert property (
		done_q |=> status.command_response_flag == $past(cr_cap))
		else $error("command response bit not copied");
	kind_copy_a: assert property (
		done_q |=> status.message_kind_code == $past(kind_cap))
		else $error("message kind not reported");
	off_hunts_a: assert property (
		!msg_receiver_on |=> state == ST_HUNT && !frame_end)
		else $error("receiver active while disabled");
	source_pick_a: assert property (
		bit_cnt == 4'h0 && oh_in.valid && msg_receiver_on |=>
		sh == (link_source_select ? $past(oh_in.nr) : $past(oh_in.gc)))
		else $error("wrong overhead octet selected");
	abort_flag_a: assert property (
		is_abort && state == ST_OPEN |=> status.abort_seen &&
		state == ST_HUNT)
		else $error("abort after flag not reported");
	buf_write_a: assert property (
		oct_full && state == ST_DATA && oct_cnt == HDR_OCTETS |=>
		u_mem.mem[0] == $past(oct_val))
		else $error("message octet not written to buffer");
	bus_answer_a: assert property (
		(avs_read || avs_write) && avs_waitrequest && !bus_pend |->
		##2 !avs_waitrequest)
		else $error("bus answer not on the expected cycle");
endmodule : lrfc_top
`default_nettype wire

// file: tb/lrfc_top_tb_top.sv
`default_nettype none
module lrfc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lrfc_pkg::*;

	// One row: identifier, address octet, source, corrupt check, kind.
	typedef struct packed {
		logic [7:0] id;
		logic [7:0] sapi;
		logic       nr;
		logic       bad;
		logic [1:0] kind;
	} lrfc_row_t;

	localparam logic [9:0] CA = {CTRL_IDX, 2'b00};
	localparam logic [9:0] SA = {STAT_IDX, 2'b00};
	localparam logic [9:0] BA = {BUF_IDX, 2'b00};

	logic        clk, rst_b, src_nr, idle, irq;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	lrfc_oh_t    oh;
	lrfc_row_t   rows [5];
	logic [7:0]  f [$];
	int          n_errors = 0;
	int          num_checks = 0;

	lrfc_top dut (
		.clk(clk), .rst_b(rst_b), .oh_in(oh), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq)
	);
	lrfc_tx_model peer (
		.clk(clk), .rst_b(rst_b), .src_nr(src_nr), .oh(oh), .idle(idle)
	);

	// Free-running 100 ns clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg

	task automatic chk_bit(string nm, logic e, logic g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic finish_test;
		$display("Checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	// Request held until waitrequest is sampled low at a rising edge;
	// read data are taken at that edge and the request dropped after it.
	// Only the watchdog ends a wait, so a dead slave still reaches Fail.
	task automatic bus(logic wr, logic [9:0] a, logic [7:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		chk_reg("wait edges", 32'h3, 32'(n));
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(logic [9:0] a, logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(string nm, logic [9:0] a, logic [31:0] m,
			logic [31:0] e);
		bus(1'b0, a, 8'h00, rd);
		chk_reg(nm, e, rd & m);
	endtask : rd_chk

	// Sender drained, then time for the closing flag and completion.
	task automatic wait_done;
		int n;
		n = 0;
		repeat (20) @(posedge clk);
		while (idle !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		repeat (60) @(posedge clk);
	endtask : wait_done

	// Main sequence: reset, table of frames, then the awkward cases.
	initial begin
		rst_b = 1'b0;
		src_nr = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		rows[0] = '{ID_PATH, 8'h3c, 1'b0, 1'b0, KIND_PATH};
		rows[1] = '{ID_IDLE, 8'h3e, 1'b1, 1'b0, KIND_IDLE};
		rows[2] = '{ID_TEST, 8'h3c, 1'b0, 1'b1, KIND_TEST};
		rows[3] = '{ID_ITU, 8'h3e, 1'b1, 1'b1, KIND_ITU};
		rows[4] = '{ID_PATH, 8'h3e, 1'b0, 1'b0, KIND_PATH};
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk("ctrl reset", CA, 32'hffffffff, {24'h0, CTRL_RESET});
		rd_chk("status reset", SA, 32'hffffffff, {24'h0, STAT_RESET});
		chk_bit("irq reset", 1'b0, irq);
		rd_chk("unmapped", 10'h010, 32'hffffffff, 32'h0);
		wr(SA, 8'hff);
		rd_chk("status ro", SA, 32'hffffffff, 32'h0);
		foreach (rows[r]) begin
			src_nr <= rows[r].nr;
			wr(CA, {4'h0, rows[r].nr, 3'b110});
			f = {rows[r].sapi, 8'h01, 8'h03, rows[r].id,
				8'hff, 8'h7e, 8'h00, 8'h3f};
			peer.send_frame(f, rows[r].bad);
			wait_done();
			chk_bit("irq", 1'b1, irq);
			rd_chk("status", SA, 32'hfe, {26'h0, rows[r].kind,
				rows[r].sapi[1], rows[r].bad, 2'b10});
			for (int i = 0; i < 5; i++)
				rd_chk("buffer", BA + 10'(4 * i), 32'hff, {24'h0, f[i + 3]});
			rd_chk("ctrl flag", CA, 32'hff, {28'h0, rows[r].nr, 3'b111});
			rd_chk("ctrl read clear", CA, 32'h01, 32'h0);
			chk_bit("irq cleared", 1'b0, irq);
		end
		wr(CA, 8'h04);
		peer.send_frame(f, 1'b0);
		wait_done();
		chk_bit("irq masked", 1'b0, irq);
		wr(CA, 8'h06);
		repeat (2) @(posedge clk);
		chk_bit("irq unmasked", 1'b1, irq);
		wr(CA, 8'h07);
		rd_chk("ctrl w1c", CA, 32'hff, 32'h06);
		wr(CA, 8'h02);
		peer.send_frame(f, 1'b0);
		wait_done();
		rd_chk("ctrl receiver off", CA, 32'hff, 32'h02);
		chk_bit("irq receiver off", 1'b0, irq);
		wr(CA, 8'h04);
		peer.put(8'h7e, 1'b0);
		peer.put(8'h7e, 1'b0);
		peer.put(8'hff, 1'b0);
		peer.put(8'h7e, 1'b0);
		wait_done();
		rd_chk("abort", SA, 32'h40, 32'h40);
		rd_chk("no flag on abort", CA, 32'h01, 32'h0);
		finish_test();
	end

	// A hang counts as a mismatch and ends the run the normal way.
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		$display("[ERR] watchdog expected done seen hang");
		finish_test();
	end
endmodule : lrfc_top_tb_top
`default_nettype wire

// file: tb/lrfc_tx_model.sv
`default_nettype none
// Far-end sender: packs an HDLC bit stream, one overhead octet per frame.
module lrfc_tx_model (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          src_nr,
	output lrfc_pkg::lrfc_oh_t oh,
	output logic               idle
);
	timeunit 1ns;
	timeprecision 1ns;
	import lrfc_pkg::*;

	logic       bits [$];
	int         ones = 0;
	int         slot = 0;
	logic [7:0] oct;

	// Bits leave LSB first; inside a frame a zero follows five ones.
	task automatic put(input logic [7:0] b, input bit stuff);
		for (int i = 0; i < 8; i++) begin
			bits.push_back(b[i]);
			ones = b[i] ? ones + 1 : 0;
			if (stuff && ones == 5) begin
				bits.push_back(1'b0);
				ones = 0;
			end
		end
		if (!stuff)
			ones = 0;
	endtask : put

	// Two flags, octets, complemented check LSB first, closing flag.
	task automatic send_frame(input logic [7:0] f [$], input bit bad);
		logic [15:0] c;
		c = CRC_INIT;
		put(8'h7e, 1'b0);
		put(8'h7e, 1'b0);
		foreach (f[k]) begin
			put(f[k], 1'b1);
			for (int i = 0; i < 8; i++)
				c = (c[0] ^ f[k][i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		c = ~c ^ {15'h0, bad};
		put(c[7:0], 1'b1);
		put(c[15:8], 1'b1);
		put(8'h7e, 1'b0);
	endtask : send_frame

	// Ten cycles per octet keeps clear of the nine-cycle spacing; the
	// unselected octet and idle cycles carry inverted data, never stale.
	always @(posedge clk) begin
		if (!rst_b) begin
			slot = 0;
			oh <= '0;
			idle <= 1'b0;
		end else begin
			slot = (slot == 9) ? 0 : slot + 1;
			oh.valid <= (slot == 0);
			if (slot == 0) begin
				if (bits.size() < 8)
					put(8'h7e, 1'b0);
				for (int i = 0; i < 8; i++)
					oct[i] = bits.pop_front();
				oh.gc <= src_nr ? ~oct : oct;
				oh.nr <= src_nr ? oct : ~oct;
			end else begin
				oh.gc <= ~oh.gc;
				oh.nr <= ~oh.nr;
			end
			idle <= (bits.size() < 8);
		end
	end
endmodule : lrfc_tx_model
`default_nettype wire
